// ### design/twi_client_pkg.sv
// constants, register map and states of the two-wire client status and command block
// ==========================================
// Summary of operation
// - complete code: acknowledge, then await start
// - complete code in host read: await start
// - response after address: acknowledge, then data
// - response after write data: acknowledge, receive
// - acknowledge bit latched before command runs
// - data-done flag set after clean byte
// - data-done flag also set on collision
// - data interrupt while flag and enable set
// - data access or command clears data-done
// - address/stop flag on match, or on stop while addressed
// - address/stop interrupt while flag and enable
// - data access or command clears address/stop
// - source bit: stop zero, address one
// - stretch clock on address match or finished byte, not on stop or collision
package twi_client_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_CTRL_A  = 8'h09;
  localparam logic [7:0] OFS_CTRL_B  = 8'h0A;
  localparam logic [7:0] OFS_STATUS  = 8'h0B;
  localparam logic [7:0] OFS_ADDR    = 8'h0C;
  localparam logic [7:0] OFS_DATA    = 8'h0D;
  // ==========================================
  // field positions
  localparam int BIT_DATA_DONE  = 7;
  localparam int BIT_ADDR_STOP  = 6;
  localparam int BIT_STRETCH    = 5;
  localparam int BIT_RX_ACK     = 4;
  localparam int BIT_CLASH      = 3;
  localparam int BIT_BUS_ERR    = 2;
  localparam int BIT_DIR        = 1;
  localparam int BIT_SOURCE     = 0;
  localparam int BIT_DATA_IE    = 7;
  localparam int BIT_ADDR_IE    = 6;
  localparam int BIT_ENABLE     = 0;
  localparam int BIT_ACK_ACTION = 2;
  // ==========================================
  // reset values and command codes
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_ADDR   = 8'h00;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [1:0] CMD_COMPLETE = 2'h2;
  localparam logic [1:0] CMD_RESPONSE = 2'h3;
  localparam logic [3:0] BYTE_LAST    = 4'h7;
  localparam logic [3:0] BYTE_FULL    = 4'h8;
  // ==========================================
  // bus states and what follows the acknowledge slot
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_HOLD, ST_ACK, ST_RX, ST_TX, ST_TXACK} bus_state_t;
  typedef enum logic [1:0] {AFTER_RX, AFTER_TX, AFTER_IDLE} after_ack_t;
endpackage

// ### design/twi_client_status_command.sv
// two-wire client: bus engine, status flags, command field and register port
`timescale 1ns/100ps
`default_nettype none
module twi_client_status_command (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output var  logic [7:0] regRdata,
  input  wire logic       sclIn,
  output var  logic       sclOut,
  output var  logic       sclOe,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  output var  logic       dataIrq,
  output var  logic       addrIrq,
  output var  logic       irq
);
  import twi_client_pkg::*;

  // ==========================================
  // pin synchronisers and edge detection
  logic sclS1_reg, sclS2_reg, sclD_reg;
  logic sdaS1_reg, sdaS2_reg, sdaD_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclS1_reg <= 1'b1;
      sclS2_reg <= 1'b1;
      sclD_reg  <= 1'b1;
      sdaS1_reg <= 1'b1;
      sdaS2_reg <= 1'b1;
      sdaD_reg  <= 1'b1;
    end else begin
      sclS1_reg <= sclIn;
      sclS2_reg <= sclS1_reg;
      sclD_reg  <= sclS2_reg;
      sdaS1_reg <= sdaIn;
      sdaS2_reg <= sdaS1_reg;
      sdaD_reg  <= sdaS2_reg;
    end
  end
  logic sclRise, sclFall, startSeen, stopSeen;
  assign sclRise   = sclS2_reg & ~sclD_reg;
  assign sclFall   = ~sclS2_reg & sclD_reg;
  // sda moving while scl stays high frames a transfer
  assign startSeen = sclS2_reg & sclD_reg & sdaD_reg & ~sdaS2_reg;
  assign stopSeen  = sclS2_reg & sclD_reg & ~sdaD_reg & sdaS2_reg;

  // ==========================================
  // register decode
  logic wrCtrlA, wrCtrlB, wrStatus, wrAddr, wrData, rdData;
  assign wrCtrlA  = regWrite && (regAddr == OFS_CTRL_A);
  assign wrCtrlB  = regWrite && (regAddr == OFS_CTRL_B);
  assign wrStatus = regWrite && (regAddr == OFS_STATUS);
  assign wrAddr   = regWrite && (regAddr == OFS_ADDR);
  assign wrData   = regWrite && (regAddr == OFS_DATA);
  assign rdData   = regRead && (regAddr == OFS_DATA);

  logic [7:0] ctrlA_reg, ownAddr_reg;
  logic       acknowledge_action_bit_reg, cmdStrobe_reg;
  logic [1:0] cmdCode_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlA_reg   <= RST_CTRL_A;
      ownAddr_reg <= RST_ADDR;
    end else begin
      if (wrCtrlA) begin
        ctrlA_reg <= regWdata;
      end
      if (wrAddr) begin
        ownAddr_reg <= regWdata;
      end
    end
  end

  // acknowledge bit stored now, command acted on one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acknowledge_action_bit_reg    <= 1'b0;
      cmdStrobe_reg <= 1'b0;
      cmdCode_reg   <= 2'h0;
    end else begin
      cmdStrobe_reg <= wrCtrlB;
      if (wrCtrlB) begin
        acknowledge_action_bit_reg  <= regWdata[BIT_ACK_ACTION];
        cmdCode_reg <= regWdata[1:0];
      end
    end
  end

  // ==========================================
  // bus engine
  bus_state_t state_reg;
  after_ack_t after_reg;
  logic [7:0] shift_reg, data_reg;
  logic [3:0] bitCnt_reg;
  logic       sclHold_reg, sdaDrive_reg, holdAddr_reg, addressed_reg;
  logic       dir_reg, received_acknowledge_flag_reg, srcFlag_reg;
  logic       doneSet_reg, addrSet_reg, clashSet_reg, busErrSet_reg;
  logic       doneFlag_reg, addrFlag_reg;
  logic       holdFlag, holdSet, holdGo, addrMatch;
  logic [1:0] holdCmd;

  assign holdFlag  = holdAddr_reg ? addrFlag_reg : doneFlag_reg;
  assign holdSet   = holdAddr_reg ? addrSet_reg : doneSet_reg;
  // a command wins; a flag cleared without one resumes as a response
  assign holdGo    = cmdStrobe_reg || (!holdFlag && !holdSet);
  assign holdCmd   = cmdStrobe_reg ? cmdCode_reg : CMD_RESPONSE;
  assign addrMatch = (shift_reg[7:1] == ownAddr_reg[7:1]) || ((shift_reg[7:1] == 7'h00) && ownAddr_reg[0]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= ST_IDLE;
      after_reg     <= AFTER_IDLE;
      shift_reg     <= 8'h00;
      data_reg      <= RST_DATA;
      bitCnt_reg    <= 4'h0;
      sclHold_reg   <= 1'b0;
      sdaDrive_reg  <= 1'b0;
      holdAddr_reg  <= 1'b0;
      addressed_reg <= 1'b0;
      dir_reg       <= 1'b0;
      received_acknowledge_flag_reg     <= 1'b0;
      srcFlag_reg   <= 1'b0;
      doneSet_reg   <= 1'b0;
      addrSet_reg   <= 1'b0;
      clashSet_reg  <= 1'b0;
      busErrSet_reg <= 1'b0;
    end else begin
      doneSet_reg   <= 1'b0;
      addrSet_reg   <= 1'b0;
      clashSet_reg  <= 1'b0;
      busErrSet_reg <= 1'b0;
      if (wrData) begin
        data_reg <= regWdata;
      end
      if (!ctrlA_reg[BIT_ENABLE]) begin
        state_reg     <= ST_IDLE;
        sclHold_reg   <= 1'b0;
        sdaDrive_reg  <= 1'b0;
        addressed_reg <= 1'b0;
      end else if (startSeen) begin
        state_reg    <= ST_ADDR;
        bitCnt_reg   <= 4'h0;
        sclHold_reg  <= 1'b0;
        sdaDrive_reg <= 1'b0;
      end else if (stopSeen) begin
        state_reg     <= ST_IDLE;
        sdaDrive_reg  <= 1'b0;
        addressed_reg <= 1'b0;
        // start then stop with no address bit between is illegal
        busErrSet_reg <= (state_reg == ST_ADDR) && (bitCnt_reg == 4'h0);
        if (addressed_reg) begin
          addrSet_reg <= 1'b1;
          srcFlag_reg <= 1'b0;
        end
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sclHold_reg <= 1'b0;
          end
          ST_ADDR: begin
            if (sclRise) begin
              shift_reg  <= {shift_reg[6:0], sdaS2_reg};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == BYTE_FULL) begin
              if (addrMatch) begin
                addressed_reg <= 1'b1;
                dir_reg       <= shift_reg[0];
                addrSet_reg   <= 1'b1;
                srcFlag_reg   <= 1'b1;
                sclHold_reg   <= 1'b1;
                holdAddr_reg  <= 1'b1;
                state_reg     <= ST_HOLD;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_HOLD: begin
            if (holdGo) begin
              sclHold_reg <= 1'b0;
              if (!holdAddr_reg && dir_reg) begin
                // host read: no acknowledge slot of ours is pending
                if (holdCmd == CMD_COMPLETE) begin
                  state_reg <= ST_IDLE;
                end else begin
                  state_reg    <= ST_TX;
                  shift_reg    <= data_reg;
                  sdaDrive_reg <= ~data_reg[7];
                  bitCnt_reg   <= 4'h0;
                end
              end else begin
                state_reg    <= ST_ACK;
                sdaDrive_reg <= ~acknowledge_action_bit_reg;
                if (holdCmd == CMD_COMPLETE) begin
                  after_reg <= AFTER_IDLE;
                end else if (holdAddr_reg && dir_reg) begin
                  after_reg <= AFTER_TX;
                end else begin
                  after_reg <= AFTER_RX;
                end
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              sdaDrive_reg <= 1'b0;
              bitCnt_reg   <= 4'h0;
              if (after_reg == AFTER_IDLE || acknowledge_action_bit_reg) begin
                state_reg <= ST_IDLE;
              end else if (after_reg == AFTER_TX) begin
                state_reg    <= ST_TX;
                shift_reg    <= data_reg;
                sdaDrive_reg <= ~data_reg[7];
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (sclRise) begin
              shift_reg  <= {shift_reg[6:0], sdaS2_reg};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == BYTE_FULL) begin
              data_reg     <= shift_reg;
              doneSet_reg  <= 1'b1;
              sclHold_reg  <= 1'b1;
              holdAddr_reg <= 1'b0;
              state_reg    <= ST_HOLD;
            end
          end
          ST_TX: begin
            if (sclRise && !sdaDrive_reg && !sdaS2_reg) begin
              // lost a released high bit: end the byte and let software look
              clashSet_reg <= 1'b1;
              doneSet_reg  <= 1'b1;
              state_reg   <= ST_IDLE;
            end else if (sclFall) begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
              if (bitCnt_reg == BYTE_LAST) begin
                sdaDrive_reg <= 1'b0;
                state_reg    <= ST_TXACK;
              end else begin
                shift_reg    <= {shift_reg[6:0], 1'b0};
                sdaDrive_reg <= ~shift_reg[6];
              end
            end
          end
          ST_TXACK: begin
            if (sclRise) begin
              received_acknowledge_flag_reg <= sdaS2_reg;
            end else if (sclFall) begin
              doneSet_reg  <= 1'b1;
              sclHold_reg  <= 1'b1;
              holdAddr_reg <= 1'b0;
              state_reg    <= ST_HOLD;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================
  // status flags: hardware set beats any clear in the same cycle
  logic autoClear, clash_reg, bus_error_flag_reg;
  assign autoClear = wrData || rdData || wrCtrlB;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      doneFlag_reg <= RST_STATUS[BIT_DATA_DONE];
      addrFlag_reg <= RST_STATUS[BIT_ADDR_STOP];
      clash_reg    <= RST_STATUS[BIT_CLASH];
      bus_error_flag_reg   <= RST_STATUS[BIT_BUS_ERR];
    end else begin
      if (doneSet_reg) begin
        doneFlag_reg <= 1'b1;
      end else if (autoClear || (wrStatus && regWdata[BIT_DATA_DONE])) begin
        doneFlag_reg <= 1'b0;
      end
      if (addrSet_reg) begin
        addrFlag_reg <= 1'b1;
      end else if (autoClear || (wrStatus && regWdata[BIT_ADDR_STOP])) begin
        addrFlag_reg <= 1'b0;
      end
      if (clashSet_reg) begin
        clash_reg <= 1'b1;
      end else if (startSeen || (wrStatus && regWdata[BIT_CLASH])) begin
        clash_reg <= 1'b0;
      end
      if (busErrSet_reg) begin
        bus_error_flag_reg <= 1'b1;
      end else if (wrStatus && regWdata[BIT_BUS_ERR]) begin
        bus_error_flag_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // read port, interrupts and pins
  logic [7:0] statusView;
  // read-only fields come from bus state only
  assign statusView = {doneFlag_reg, addrFlag_reg, sclHold_reg, received_acknowledge_flag_reg, clash_reg, bus_error_flag_reg, dir_reg, srcFlag_reg};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        OFS_CTRL_A: regRdata <= ctrlA_reg;
        OFS_CTRL_B: regRdata <= {5'h00, acknowledge_action_bit_reg, 2'h0};
        OFS_STATUS: regRdata <= statusView;
        OFS_ADDR:   regRdata <= ownAddr_reg;
        OFS_DATA:   regRdata <= data_reg;
        default:    regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataIrq <= 1'b0;
      addrIrq <= 1'b0;
      irq     <= 1'b0;
      sclOut  <= 1'b0;
      sdaOut  <= 1'b0;
      sclOe   <= 1'b0;
      sdaOe   <= 1'b0;
    end else begin
      dataIrq <= doneFlag_reg && ctrlA_reg[BIT_DATA_IE];
      addrIrq <= addrFlag_reg && ctrlA_reg[BIT_ADDR_IE];
      irq     <= (doneFlag_reg && ctrlA_reg[BIT_DATA_IE]) || (addrFlag_reg && ctrlA_reg[BIT_ADDR_IE]);
      // open drain: only ever pull low
      sclOut  <= 1'b0;
      sdaOut  <= 1'b0;
      sclOe   <= sclHold_reg;
      sdaOe   <= sdaDrive_reg;
    end
  end
endmodule
`default_nettype wire

// ### test/twi_client_properties.sv
// port-level assertions for the two-wire client block
`timescale 1ns/100ps
`default_nettype none
module twi_client_properties
  import twi_client_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       dataIrq,
  input wire logic       addrIrq,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // assertions
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
    else $error("wire driven high");
  AST_DATA_CLR: assert property (regRead && regAddr == OFS_DATA |-> ##[1:3] !dataIrq)
    else $error("data read left data flag");
  AST_CMD_CLR: assert property (regWrite && regAddr == OFS_CTRL_B |-> ##[1:3] !addrIrq && !dataIrq)
    else $error("command write left a flag");
  AST_DIF_HOLDS_SCL: assert property ($rose(dataIrq) |-> ##[0:3] sclOe)
    else $error("no stretch on data flag");
  AST_HOLD_HAS_CAUSE: assert property ($rose(sclOe) |-> ##[0:2] irq)
    else $error("stretch without a flag");
  AST_IRQ_FROM_FLAGS: assert property (irq |-> dataIrq || addrIrq || $past(dataIrq || addrIrq))
    else $error("irq without source");
  AST_IRQ_FOLLOWS: assert property (dataIrq || addrIrq |-> ##[0:1] irq)
    else $error("irq missing");
  AST_STATUS_DIF: assert property (regRead && regAddr == OFS_STATUS ##1 dataIrq |-> regRdata[BIT_DATA_DONE])
    else $error("status lacks data flag");
  COV_DATA: cover property ($rose(dataIrq));
  COV_ADDR: cover property ($rose(addrIrq));
  COV_RELEASE: cover property ($fell(sclOe));
endmodule
bind twi_client_status_command twi_client_properties u_props (.clk(clk), .resetn(resetn),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .dataIrq(dataIrq), .addrIrq(addrIrq), .irq(irq));
`default_nettype wire

// ### test/twi_host_model.sv
// behavioural bus host on open-drain clock and data wires
`timescale 1ns/100ps
`default_nettype none
module twi_host_model (
  input  wire logic sclOe,
  input  wire logic sdaOe,
  output var  logic scl,
  output var  logic sda
);
  logic sclRel = 1'b1;
  logic sdaRel = 1'b1;
  logic s;
  // ==========================================
  // wires with pull-ups
  assign scl = sclRel & ~sclOe;
  assign sda = sdaRel & ~sdaOe;
  // ==========================================
  // bus phases, 124 ns bit time
  // client may stretch the low phase, so wait on the wire itself
  task automatic riseScl(output logic v);
    sclRel = 1'b1;
    for (int i = 0; i < 5000 && !scl; i++) #10;
    #31 v = sda;
    #31;
  endtask
  task automatic startCond();
    sdaRel = 1'b1;
    riseScl(s);
    sdaRel = 1'b0;
    #62 sclRel = 1'b0;
    #31;
  endtask
  task automatic stopCond();
    sdaRel = 1'b0;
    #31 riseScl(s);
    sdaRel = 1'b1;
    #62;
  endtask
  // host read: release sda for 8 bits, then give ackBit
  task automatic recvByte(input logic ackBit, output logic [7:0] b);
    logic v;
    for (int k = 7; k >= 0; k--) begin
      sdaRel = 1'b1;
      #31 riseScl(v);
      b[k] = v;
      sclRel = 1'b0;
      #31;
    end
    sdaRel = ackBit;
    #31 riseScl(v);
    sclRel = 1'b0;
    #31;
  endtask
  // msb first, then the acknowledge slot
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int k = 7; k >= -1; k--) begin
      sdaRel = (k < 0) ? 1'b1 : b[k];
      #31 riseScl(ack);
      sclRel = 1'b0;
      #31;
    end
  endtask
endmodule
`default_nettype wire

// ### test/twi_client_status_command_bench.sv
// self-checking bench for the two-wire client status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("mismatch %0t got %h", $time, a); end end
module twi_client_status_command_bench;
  import twi_client_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdata, rd, dat, txb;
  logic       sclOut, sclOe, sdaOut, sdaOe, dataIrq, addrIrq, irq, scl, sda, ack;
  logic [6:0] own;
  int         fail_count = 0;
  int         checked = 0;
  int         cycles = 0;
  always #5 clk = ~clk;
  twi_client_status_command u_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .dataIrq(dataIrq), .addrIrq(addrIrq), .irq(irq));
  twi_host_model u_host (.sclOe(sclOe), .sdaOe(sdaOe), .scl(scl), .sda(sda));
  // ==========================================
  // helpers
  task automatic test_done();
    $display("counts: %0d mismatches, %0d checks", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // bounded wait, then let the stretch settle
  task automatic waitIrq(input logic addrSide);
    for (int n = 0; n < 3000 && !(addrSide ? addrIrq : dataIrq); n++) @(posedge clk);
    `CHK(addrSide ? addrIrq : dataIrq, 1'b1)
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [7:0] expStat(logic d, logic a, logic h, logic ap);
    return {d, a, h, 4'h0, ap};
  endfunction
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(13764));
    own = 7'h08 + 7'($urandom % 100);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdReg(OFS_STATUS, rd);
    `CHK(rd, 8'h00)
    wr(OFS_STATUS, 8'hFF);
    rdReg(OFS_STATUS, rd);
    `CHK(rd, 8'h00)
    rdReg(8'h0F, rd);
    `CHK(rd, 8'h00)
    wr(OFS_CTRL_A, 8'hC1);
    wr(OFS_ADDR, {own, 1'b0});
    fork
      begin
        u_host.startCond();
        u_host.sendByte({own, 1'b0}, ack);
        `CHK(ack, 1'b0)
      end
      begin
        waitIrq(1'b1);
        rdReg(OFS_STATUS, rd);
        `CHK(rd, expStat(1'b0, 1'b1, 1'b1, 1'b1))
        wr(OFS_CTRL_B, 8'h03);
      end
    join
    `CHK(addrIrq, 1'b0)
    for (int k = 0; k < 2; k++) begin
      dat = 8'($urandom);
      fork
        begin
          u_host.sendByte(dat, ack);
          `CHK(ack, 1'b0)
        end
        begin
          waitIrq(1'b0);
          rdReg(OFS_STATUS, rd);
          `CHK(rd[7:5], 3'b101)
          if (k == 1) wr(OFS_CTRL_B, 8'h03);
          rdReg(OFS_DATA, rd);
          `CHK(rd, dat)
        end
      join
      `CHK(dataIrq, 1'b0)
    end
    // stop with the address interrupt masked
    wr(OFS_CTRL_A, 8'h81);
    u_host.stopCond();
    repeat (8) @(posedge clk);
    `CHK(addrIrq, 1'b0)
    rdReg(OFS_STATUS, rd);
    `CHK({rd[6], rd[0]}, 2'b10)
    wr(OFS_STATUS, 8'h40);
    rdReg(OFS_STATUS, rd);
    `CHK(rd[6], 1'b0)
    // host read: response sends the data byte, completion then idles
    txb = 8'($urandom);
    wr(OFS_DATA, txb);
    wr(OFS_CTRL_A, 8'hC1);
    fork
      begin
        u_host.startCond();
        u_host.sendByte({own, 1'b1}, ack);
        `CHK(ack, 1'b0)
        u_host.recvByte(1'b1, dat);
        `CHK(dat, txb)
      end
      begin
        waitIrq(1'b1);
        wr(OFS_CTRL_B, 8'h03);
        waitIrq(1'b0);
        rdReg(OFS_STATUS, rd);
        `CHK(rd, 8'hB3)
        wr(OFS_CTRL_B, 8'h02);
        repeat (4) @(posedge clk);
        `CHK(sclOe, 1'b0)
        `CHK(sdaOe, 1'b0)
      end
    join
    // refusal and completion given in one write
    wr(OFS_CTRL_A, 8'hC1);
    fork
      begin
        u_host.startCond();
        u_host.sendByte({own, 1'b0}, ack);
        `CHK(ack, 1'b1)
      end
      begin
        waitIrq(1'b1);
        wr(OFS_CTRL_B, 8'h06);
      end
    join
    u_host.sendByte(8'($urandom), ack);
    `CHK(ack, 1'b1)
    `CHK(dataIrq, 1'b0)
    u_host.stopCond();
    test_done();
  end
endmodule
`default_nettype wire
